// file: design/epv_addr_latch.sv
// Two-phase address latch fed from port 3
`timescale 1ns/1ps
`default_nettype none
module epv_addr_latch #(
   parameter int unsigned ADDR_W = epv_pkg::ADDR_W
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              address_half_select,
   input  wire logic [7:0]        port3_in,
   output logic [ADDR_W-1:0]      addr,
   output logic                   addr_stable
);
   localparam int unsigned HW = ADDR_W - 8;
   typedef struct packed {
      logic          address_half_select_prev;
      logic [HW-1:0] hi;
      logic [7:0]    cand;
      logic [7:0]    lo;
      logic [3:0]    scnt;
      logic          stable;
   } epv_al_t;
   epv_al_t q, d;

   // High part on the falling select; low byte once it sat still
   always_comb begin
      d = q;
      d.address_half_select_prev = address_half_select;
      if (q.address_half_select_prev && !address_half_select) begin
         d.hi = port3_in[HW-1:0];
      end
      if (address_half_select) begin
         // Select high stops the low path; the far end holds it long enough
         d.cand   = port3_in;
         d.scnt   = 4'h0;
         d.stable = 1'b0;
      end else if (port3_in != q.cand) begin
         d.cand   = port3_in;
         d.scnt   = 4'h0;
         d.stable = 1'b0;
      end else if (q.scnt == 4'(epv_pkg::LOW_STABLE_CLKS - 1)) begin
         d.lo     = q.cand;
         d.stable = 1'b1;
      end else begin
         d.scnt = q.scnt + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Only the low byte may change without a new select pulse
   assign addr        = {q.hi, q.lo};
   assign addr_stable = q.stable;
endmodule
`default_nettype wire

// file: design/epv_code_rx.sv
// Serial mode-code receiver on the reset pin
`timescale 1ns/1ps
`default_nettype none
module epv_code_rx (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       reset_pin,
   output logic [9:0]      code,
   output logic            code_done,
   output logic            session
);
   typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_SHIFT, RX_HOLD} epv_rx_st_t;
   typedef struct packed {
      epv_rx_st_t st;
      logic [4:0] hcnt;
      logic [3:0] bcnt;
      logic [9:0] sh;
      logic       done;
   } epv_rx_t;
   epv_rx_t q, d;

   // Arm after a long high, then take one bit per clock, LSB first
   always_comb begin
      d = q;
      d.done = 1'b0;
      case (q.st)
         RX_IDLE: begin
            if (!reset_pin) begin
               d.hcnt = 5'h00;
            end else if (q.hcnt == 5'(epv_pkg::RST_HOLD_CLKS - 1)) begin
               d.st = RX_ARMED;
            end else begin
               d.hcnt = q.hcnt + 5'h01;
            end
         end
         RX_ARMED: begin
            // First low level is bit 0 of every defined code
            if (!reset_pin) begin
               d.sh   = {reset_pin, q.sh[9:1]};
               d.bcnt = 4'h1;
               d.st   = RX_SHIFT;
            end
         end
         RX_SHIFT: begin
            d.sh   = {reset_pin, q.sh[9:1]};
            d.bcnt = q.bcnt + 4'h1;
            if (q.bcnt == 4'(epv_pkg::CODE_W - 1)) begin
               d.done = 1'b1;
               d.st   = RX_HOLD;
            end
         end
         RX_HOLD: begin
            // Pin back high ends the session
            if (reset_pin) begin
               d.st   = RX_IDLE;
               d.hcnt = 5'h01;
            end
         end
         default: d.st = RX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{st: RX_IDLE, hcnt: 5'h00, bcnt: 4'h0, sh: 10'h000, done: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign code      = q.sh;
   assign code_done = q.done;
   assign session   = (q.st == RX_HOLD);
endmodule
`default_nettype wire

// file: design/epv_pkg.sv
// Shared constants and types for the program/verify port
package epv_pkg;
   // Serial mode entry
   localparam int unsigned MACH_CLKS     = 12;
   localparam int unsigned RST_MACH      = 2;
   localparam int unsigned RST_HOLD_CLKS = MACH_CLKS * RST_MACH;
   localparam int unsigned CODE_W        = 10;
   localparam logic [9:0]  CODE_USER     = 10'h296;
   localparam logic [9:0]  CODE_KEY      = 10'h292;
   localparam logic [9:0]  CODE_SEC1     = 10'h29A;
   localparam logic [9:0]  CODE_SEC2     = 10'h298;
   // Address multiplexing; timings counted in clock cycles, ADDR_W in bits
   localparam int unsigned ADDRESS_HALF_SELECT_HIGH_CLKS  = 13;
   localparam int unsigned ADDR_HOLD_CLKS  = 2;
   localparam int unsigned LOW_STABLE_CLKS = 13;
   localparam int unsigned ADDR_W          = 11;
   // Program and verify
   localparam int unsigned VERIFY_CLKS = 48;
   localparam int unsigned PGM_PULSES  = 5;
   localparam int unsigned KEY_DEPTH   = 64;
   localparam logic [7:0]  BLOCK_BYTE  = 8'hFF;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;
   localparam int unsigned SEC1_POS    = 7;
   localparam int unsigned SEC2_POS    = 6;
   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_USER,
      MODE_KEY,
      MODE_SEC1,
      MODE_SEC2
   } epv_mode_t;
endpackage

// file: design/epv_port.sv
// Program and verify port of the one-time-programmable code memory
`timescale 1ns/1ps
`default_nettype none
module epv_port #(
   parameter int unsigned ADDR_W    = epv_pkg::ADDR_W,
   parameter int unsigned KEY_DEPTH = epv_pkg::KEY_DEPTH
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       reset_pin,
   input  wire logic       address_half_select,
   input  wire logic [7:0] port3_in,
   input  wire logic [7:0] port1_in,
   output logic [7:0]      port1_out,
   output logic [7:0]      port1_oe,
   input  wire logic       program_strobe_n,
   input  wire logic       vpp_applied,
   output logic            prog_pins_pullup,
   input  wire logic       erase_req,
   input  wire logic       masked_rom,
   input  wire logic       external_access_n,
   output logic            external_access_eff_n,
   output logic            ext_code_read_en,
   output logic            session_active,
   output logic            mode_rejected,
   output logic            sec1_state,
   output logic            sec2_state
);
   localparam int unsigned KW    = $clog2(KEY_DEPTH);
   localparam int unsigned DEPTH = 2 ** ADDR_W;

   // Refuse shapes the address split cannot serve
   if (ADDR_W < 9 || ADDR_W > 12 || KEY_DEPTH < 2 || KEY_DEPTH != 2 ** KW
       || KEY_DEPTH > 256) begin : g_bad_param
      $error("epv_port: unsupported ADDR_W or KEY_DEPTH");
   end

   typedef struct packed {
      logic [2:0] pulses;
      logic [5:0] vcnt;
      logic [7:0] p1;
      logic       pgm_prev;
      logic       ea_latch;
      logic       ea_taken;
   } epv_st_t;
   epv_st_t q, d;

   logic [9:0]        code;
   logic              code_done;
   logic              session;
   logic [ADDR_W-1:0] addr;
   logic              addr_stable;
   epv_pkg::epv_mode_t mode;
   logic              wr_go;
   logic [7:0]        verify_byte;
   logic [7:0]        user_byte;
   logic [7:0]        key_byte;

   // Nonvolatile contents: no reset, only erase clears them
   logic [7:0] user_mem [DEPTH];
   logic [7:0] key_mem  [KEY_DEPTH];
   logic       sec1_q;
   logic       sec2_q;

   epv_code_rx u_code_rx (
      .clk       (clk),
      .arst_n    (arst_n),
      .reset_pin (reset_pin),
      .code      (code),
      .code_done (code_done),
      .session   (session)
   );

   epv_addr_latch #(
      .ADDR_W (ADDR_W)
   ) u_addr (
      .clk                 (clk),
      .arst_n              (arst_n),
      .address_half_select (address_half_select),
      .port3_in            (port3_in),
      .addr                (addr),
      .addr_stable         (addr_stable)
   );

   // Decode the received code; anything else selects nothing
   always_comb begin
      mode = epv_pkg::MODE_NONE;
      if (session) begin
         case (code)
            epv_pkg::CODE_USER: mode = epv_pkg::MODE_USER;
            epv_pkg::CODE_KEY:  mode = epv_pkg::MODE_KEY;
            epv_pkg::CODE_SEC1: mode = epv_pkg::MODE_SEC1;
            epv_pkg::CODE_SEC2: mode = epv_pkg::MODE_SEC2;
            default:            mode = epv_pkg::MODE_NONE;
         endcase
      end
   end

   // Array reads; key entry wraps every KEY_DEPTH bytes
   assign user_byte = user_mem[addr];
   assign key_byte  = key_mem[addr[KW-1:0]];

   // Verify data by mode, with the security gates applied
   always_comb begin
      verify_byte = epv_pkg::BLOCK_BYTE;
      case (mode)
         epv_pkg::MODE_USER: begin
            if (!sec2_q) begin
               // Erased key bytes are all ones, so XNOR passes data through
               verify_byte = ~(user_byte ^ key_byte);
            end
         end
         epv_pkg::MODE_KEY: begin
            if (!sec1_q && !sec2_q) begin
               verify_byte = key_byte;
            end
         end
         epv_pkg::MODE_SEC1: begin
            verify_byte = 8'h00;
            verify_byte[epv_pkg::SEC1_POS] = sec1_q;
            verify_byte[epv_pkg::SEC2_POS] = sec2_q;
         end
         default: verify_byte = epv_pkg::BLOCK_BYTE;
      endcase
   end

   // Fifth strobe rise under programming voltage commits the write
   assign wr_go = session && vpp_applied && !q.pgm_prev && program_strobe_n
                  && (q.pulses == 3'(epv_pkg::PGM_PULSES - 1));

   // Pulse counting, verify delay, port 1 data and strap capture
   always_comb begin
      d = q;
      d.pgm_prev = program_strobe_n;
      // Access pin taken once, on the first edge after reset release
      if (!q.ea_taken) begin
         d.ea_latch = external_access_n;
         d.ea_taken = 1'b1;
      end
      if (!session || code_done) begin
         d.pulses = 3'h0;
         d.vcnt   = 6'h00;
      end else if (vpp_applied) begin
         d.vcnt = 6'h00;
         if (!q.pgm_prev && program_strobe_n) begin
            d.pulses = wr_go ? 3'h0 : q.pulses + 3'h1;
         end
      end else begin
         d.pulses = 3'h0;
         // Old data stays on the pins until the delay has run
         if (q.vcnt != 6'(epv_pkg::VERIFY_CLKS - 1)) begin
            d.vcnt = q.vcnt + 6'h01;
         end else if (addr_stable) begin
            d.p1 = verify_byte;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Array writes only clear bits, security writes set them; erase restores arrays to all ones and clears security bits
   always_ff @(posedge clk) begin
      if (erase_req) begin
         for (int i = 0; i < DEPTH; i++) begin
            user_mem[i] <= epv_pkg::ERASED_BYTE;
         end
         for (int k = 0; k < KEY_DEPTH; k++) begin
            key_mem[k] <= epv_pkg::ERASED_BYTE;
         end
         sec1_q <= 1'b0;
         sec2_q <= 1'b0;
      end else if (wr_go) begin
         case (mode)
            epv_pkg::MODE_USER: begin
               if (!sec1_q) begin
                  user_mem[addr] <= user_mem[addr] & port1_in;
               end
            end
            epv_pkg::MODE_KEY: begin
               if (!sec1_q) begin
                  key_mem[addr[KW-1:0]] <= key_byte & port1_in;
               end
            end
            epv_pkg::MODE_SEC1: sec1_q <= 1'b1;
            epv_pkg::MODE_SEC2: sec2_q <= 1'b1;
            default: ;
         endcase
      end
   end

   // Port 1 drives in a decoded mode outside programming voltage, listens under it
   assign port1_oe  = (mode != epv_pkg::MODE_NONE && !vpp_applied) ? 8'hFF : 8'h00;
   assign port1_out = q.p1;

   // Strobe and voltage pins idle high as port pins outside a session
   assign prog_pins_pullup = !session;

   // Masked parts with security bit 1 use the captured access level
   assign ext_code_read_en      = !(masked_rom && sec1_q);
   assign external_access_eff_n = (masked_rom && sec1_q) ? q.ea_latch
                                                          : external_access_n;

   assign session_active = session;
   assign mode_rejected  = session && (mode == epv_pkg::MODE_NONE);
   assign sec1_state     = sec1_q;
   assign sec2_state     = sec2_q;
endmodule
`default_nettype wire

// file: verification/epv_port_checker.sv
// Port-level assertions for the program and verify port
`timescale 1ns/1ps
`default_nettype none
module epv_port_checker (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       reset_pin,
   input wire logic       vpp_applied,
   input wire logic       erase_req,
   input wire logic       masked_rom,
   input wire logic [7:0] port1_out,
   input wire logic [7:0] port1_oe,
   input wire logic       prog_pins_pullup,
   input wire logic       ext_code_read_en,
   input wire logic       session_active,
   input wire logic       mode_rejected,
   input wire logic       sec1_state
);
   logic       live_q;
   logic [5:0] low_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Security bits are unknown until the first erase, so gate on it
   always_ff @(posedge clk) begin
      if (erase_req) live_q <= 1'b1;
   end
   // Cycles at normal voltage inside a session, saturating
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) low_q <= 6'h00;
      else if (!session_active || vpp_applied) low_q <= 6'h00;
      else if (low_q != 6'h3F) low_q <= low_q + 6'h01;
   end
   a_vpp_port_in: assert property (vpp_applied |-> port1_oe == 8'h00)
      else $error("port 1 driven under programming voltage");
   a_oe_needs_mode: assert property (port1_oe != 8'h00 |-> session_active)
      else $error("port 1 driven outside a session");
   a_reject_quiet: assert property (mode_rejected |-> session_active && port1_oe == 8'h00)
      else $error("unknown code drives port 1");
   a_pullup_idle: assert property (prog_pins_pullup == !session_active)
      else $error("pin pull-up does not follow session");
   a_code_frame: assert property ($rose(session_active) |-> $past(reset_pin, 11) && !$past(reset_pin, 10))
      else $error("session opened without a ten bit frame");
   a_session_drop: assert property (session_active && reset_pin |-> ##[1:2] !session_active)
      else $error("session survives reset pin high");
   a_verify_wait: assert property ($changed(port1_out) && session_active && !vpp_applied |-> low_q >= 6'h30)
      else $error("verify data before the delay");
   a_ext_read_lock: assert property (live_q |-> ext_code_read_en == !(masked_rom && sec1_state))
      else $error("external read enable wrong");
   a_sec1_cause: assert property (live_q && $rose(sec1_state) |-> $past(vpp_applied) && $past(session_active))
      else $error("security bit 1 set outside programming");
   c_session: cover property ($rose(session_active));
   c_reject: cover property ($rose(mode_rejected));
   c_sec1: cover property (live_q && $rose(sec1_state));
endmodule
bind epv_port epv_port_checker u_chk (
   .clk(clk), .arst_n(arst_n), .reset_pin(reset_pin), .vpp_applied(vpp_applied),
   .erase_req(erase_req), .masked_rom(masked_rom), .port1_out(port1_out), .port1_oe(port1_oe),
   .prog_pins_pullup(prog_pins_pullup), .ext_code_read_en(ext_code_read_en),
   .session_active(session_active), .mode_rejected(mode_rejected), .sec1_state(sec1_state));
`default_nettype wire

// file: verification/epv_port_tb.sv
// Self-checking bench for the program and verify port
`timescale 1ns/1ps
`default_nettype none
module epv_port_tb;
   logic       clk, arst_n, erase_req, masked_rom, external_access_n;
   logic       reset_pin, address_half_select, program_strobe_n, vpp_applied;
   logic [7:0] port3_in, port1_in, port1_out, port1_oe;
   logic       prog_pins_pullup, external_access_eff_n, ext_code_read_en;
   logic       session_active, mode_rejected, sec1_state, sec2_state;
   int         fails, num_checks, cycles;
   epv_port u_dut (
      .clk                   (clk),
      .arst_n                (arst_n),
      .reset_pin             (reset_pin),
      .address_half_select   (address_half_select),
      .port3_in              (port3_in),
      .port1_in              (port1_in),
      .port1_out             (port1_out),
      .port1_oe              (port1_oe),
      .program_strobe_n      (program_strobe_n),
      .vpp_applied           (vpp_applied),
      .prog_pins_pullup      (prog_pins_pullup),
      .erase_req             (erase_req),
      .masked_rom            (masked_rom),
      .external_access_n     (external_access_n),
      .external_access_eff_n (external_access_eff_n),
      .ext_code_read_en      (ext_code_read_en),
      .session_active        (session_active),
      .mode_rejected         (mode_rejected),
      .sec1_state            (sec1_state),
      .sec2_state            (sec2_state)
   );
   epv_prog_model u_prog (
      .clk                 (clk),
      .port1_out           (port1_out),
      .port1_oe            (port1_oe),
      .reset_pin           (reset_pin),
      .address_half_select (address_half_select),
      .port3_in            (port3_in),
      .port1_in            (port1_in),
      .program_strobe_n    (program_strobe_n),
      .vpp_applied         (vpp_applied)
   );
   always #5 clk = ~clk;
   // Hang guard; the full run needs well under 4000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         finish_test();
      end
   end
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      if (fails == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Write, verify, and move the address by halves
   task automatic t_user();
      chk8("pullup", 8'h01, {7'h00, prog_pins_pullup});
      u_prog.enter(epv_pkg::CODE_USER);
      chk8("session", 8'h01, {7'h00, session_active});
      chk8("accepted", 8'h00, {7'h00, mode_rejected});
      chk8("pullup off", 8'h00, {7'h00, prog_pins_pullup});
      u_prog.set_addr(11'h541);
      chk8("oe setup", 8'hFF, port1_oe);
      u_prog.burn(8'hA5);
      chk8("user", 8'hA5, port1_out);
      u_prog.set_low(8'h40);
      u_prog.step(8);
      chk8("low only", 8'hFF, port1_out);
      u_prog.set_low(8'h41);
      u_prog.step(8);
      chk8("low back", 8'hA5, port1_out);
      u_prog.set_addr(11'h141);
      u_prog.step(8);
      chk8("high part", 8'hFF, port1_out);
   endtask
   // Key entry 1 scrambles code address 0x541
   task automatic t_key();
      u_prog.enter(epv_pkg::CODE_KEY);
      u_prog.set_addr(11'h001);
      u_prog.burn(8'h0F);
      chk8("key", 8'h0F, port1_out);
      u_prog.enter(epv_pkg::CODE_USER);
      u_prog.set_addr(11'h541);
      u_prog.step(52);
      chk8("xnor", 8'h55, port1_out);
      u_prog.enter(10'h2F0);
      chk8("rejected", 8'h01, {7'h00, mode_rejected});
      chk8("reject oe", 8'h00, port1_oe);
      u_prog.burn(8'h00);
      u_prog.enter(epv_pkg::CODE_USER);
      u_prog.step(52);
      chk8("untouched", 8'h55, port1_out);
   endtask
   // Security bits and what they lock
   task automatic t_sec();
      external_access_n = 1'b1;
      u_prog.step(2);
      chk8("ea live", 8'h01, {7'h00, external_access_eff_n});
      chk8("read en on", 8'h01, {7'h00, ext_code_read_en});
      u_prog.enter(epv_pkg::CODE_SEC1);
      u_prog.burn(8'h00);
      chk8("sec1", 8'h80, port1_out);
      chk8("sec1 bit", 8'h01, {7'h00, sec1_state});
      chk8("ea held", 8'h00, {7'h00, external_access_eff_n});
      chk8("read en", 8'h00, {7'h00, ext_code_read_en});
      u_prog.enter(epv_pkg::CODE_USER);
      u_prog.burn(8'h00);
      chk8("no rewrite", 8'h55, port1_out);
      u_prog.enter(epv_pkg::CODE_KEY);
      u_prog.step(52);
      chk8("key hidden", 8'hFF, port1_out);
      u_prog.enter(epv_pkg::CODE_SEC2);
      u_prog.burn(8'h00);
      chk8("sec2", 8'h01, {7'h00, sec2_state});
      chk8("sec2 verify", 8'hFF, port1_out);
      u_prog.enter(epv_pkg::CODE_SEC1);
      u_prog.step(52);
      chk8("sec both", 8'hC0, port1_out);
      u_prog.enter(epv_pkg::CODE_USER);
      u_prog.step(52);
      chk8("user hidden", 8'hFF, port1_out);
      // Programmable part: security bit 1 leaves code reads and the pin alone
      masked_rom = 1'b0;
      u_prog.step(1);
      chk8("unmasked en", 8'h01, {7'h00, ext_code_read_en});
      chk8("unmasked ea", 8'h01, {7'h00, external_access_eff_n});
   endtask
   // Reset with erase held, then the scenarios
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      erase_req = 1'b1;
      masked_rom = 1'b1;
      external_access_n = 1'b0;
      fails = 0;
      num_checks = 0;
      cycles = 0;
      u_prog.step(16);
      arst_n = 1'b1;
      u_prog.step(2);
      erase_req = 1'b0;
      t_user();
      t_key();
      t_sec();
      finish_test();
   end
endmodule
`default_nettype wire

// file: verification/epv_prog_model.sv
// Behavioural programmer on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module epv_prog_model (
   input  wire logic       clk,
   input  wire logic [7:0] port1_out,
   input  wire logic [7:0] port1_oe,
   output logic            reset_pin,
   output logic            address_half_select,
   output logic [7:0]      port3_in,
   output logic [7:0]      port1_in,
   output logic            program_strobe_n,
   output logic            vpp_applied
);
   logic [7:0] drv;
   // Quasi-bidirectional port: programmer under voltage, else device where enabled, pull-ups elsewhere
   assign port1_in = vpp_applied ? drv : ((port1_oe & port1_out) | ~port1_oe);
   // Pins start in the idle reset state
   initial begin
      reset_pin = 1'b1;
      address_half_select = 1'b0;
      port3_in = 8'h00;
      drv = 8'h00;
      program_strobe_n = 1'b1;
      vpp_applied = 1'b0;
   end
   // Pins move in the clock-low half, clear of the sampling high time
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #6;
   endtask
   // Long high arms the receiver, then the code goes out LSB first
   task automatic enter(input logic [9:0] code);
      program_strobe_n = 1'b1;
      vpp_applied = 1'b0;
      reset_pin = 1'b1;
      step(30);
      for (int i = 0; i < 10; i++) begin
         reset_pin = code[i];
         step(1);
      end
      reset_pin = 1'b0;
      step(2);
   endtask
   task automatic set_low(input logic [7:0] lo);
      port3_in = lo;
      step(16);
   endtask
   task automatic set_addr(input logic [10:0] a);
      address_half_select = 1'b1;
      port3_in = {5'h00, a[10:8]};
      step(14);
      address_half_select = 1'b0;
      step(3);
      set_low(a[7:0]);
   endtask
   // Five strobe pulses under voltage, then back to verify
   task automatic burn(input logic [7:0] d);
      drv = d;
      vpp_applied = 1'b1;
      step(4);
      repeat (5) begin
         program_strobe_n = 1'b0;
         step(2);
         program_strobe_n = 1'b1;
         step(2);
      end
      vpp_applied = 1'b0;
      step(52);
   endtask
endmodule
`default_nettype wire
